// ### rtl/mfd_top.sv
// Purpose: Flag register and DMA channel map register block
// Assumes: Register port strobes one cycle, never both at once
// Notes:   Read data valid only in the cycle after the read strobe
`timescale 1ns/1ps
`include "mfd_consts.svh"

module mfd_top (
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  input  wire logic                 daughter_event_in,
  input  wire logic                 boot_master_site,
  input  wire logic                 site1_absent,
  input  wire logic                 site2_absent,
  output logic                      dev_ctrl_suspend_line,
  output logic                      dev_ctrl_suspend_line_oe,
  output logic                      host_ctrl_suspend_line,
  output logic                      host_ctrl_suspend_line_oe,
  output logic                      flash_select,
  output logic      [1:0]           daughter_event_out,
  output logic                      soft_interrupt,
  input  wire mfd_pkg::mfd_periph_t periph_req_n,
  output mfd_pkg::mfd_periph_t      periph_ack_n,
  output logic      [1:0]           dma_req_ack_pair_n_req,
  input  wire logic [1:0]           dma_req_ack_pair_n_ack
);

  mfd_pkg::mfd_bus_req_t req;
  mfd_pkg::mfd_dma_sel_t dma_sel;
  logic                  route_en;
  logic                  hit_misc;
  logic                  hit_dma;
  logic                  hit_route;
  logic                  wr_misc;
  logic [31:0]           misc_word;
  logic [31:0]           dma_word;
  logic [31:0]           route_word;
  logic [31:0]           next_rdata;

  // ****************************************
  // Address decode
  // ****************************************
  assign req       = '{addr: reg_addr, wdata: reg_wdata,
                       wr: reg_wr, rd: reg_rd};
  assign hit_misc  = req.addr == `MFD_OFS_MISC;
  assign hit_dma   = req.addr == `MFD_OFS_DMA_MAP;
  assign hit_route = req.addr == `MFD_OFS_ROUTE_CTRL;
  assign wr_misc   = req.wr && hit_misc;

  // ****************************************
  // Flag register
  // ****************************************
  mfd_misc_reg u_misc (
    .ref_clk                   (ref_clk),
    .reset_n                   (reset_n),
    .wr_en                     (wr_misc),
    .wdata                     (req.wdata),
    .daughter_event_in         (daughter_event_in),
    .boot_master_site          (boot_master_site),
    .site1_absent              (site1_absent),
    .site2_absent              (site2_absent),
    .rdata                     (misc_word),
    .dev_ctrl_suspend_line     (dev_ctrl_suspend_line),
    .dev_ctrl_suspend_line_oe  (dev_ctrl_suspend_line_oe),
    .host_ctrl_suspend_line    (host_ctrl_suspend_line),
    .host_ctrl_suspend_line_oe (host_ctrl_suspend_line_oe),
    .flash_select              (flash_select),
    .daughter_event_out        (daughter_event_out),
    .soft_interrupt            (soft_interrupt)
  );

  // ****************************************
  // DMA map and route control registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      dma_sel  <= mfd_pkg::mfd_dma_sel_t'(`MFD_RST_DMA_SEL);
      route_en <= `MFD_RST_ROUTE_EN;
    end else begin
      if (req.wr && hit_dma) begin
        dma_sel <= mfd_pkg::mfd_dma_sel_t'(
          req.wdata[`MFD_DMA_SEL_HI:`MFD_DMA_SEL_LO]);
      end
      if (req.wr && hit_route) begin
        route_en <= req.wdata[`MFD_ROUTE_EN];
      end
    end
  end

  assign dma_word   = {30'h0000_0000, dma_sel};
  assign route_word = {31'h0000_0000, route_en};

  // ****************************************
  // DMA pair steering
  // ****************************************
  mfd_dma_route u_route (
    .dma_sel      (dma_sel),
    .route_en     (route_en),
    .periph_req_n (periph_req_n),
    .chan_ack_n   (dma_req_ack_pair_n_ack),
    .chan_req_n   (dma_req_ack_pair_n_req),
    .periph_ack_n (periph_ack_n)
  );

  // ****************************************
  // Read data, one cycle after the strobe
  // ****************************************
  assign next_rdata = !req.rd   ? `MFD_RST_RDATA :
                      hit_misc  ? misc_word :
                      hit_dma   ? dma_word :
                      hit_route ? route_word : `MFD_RST_RDATA;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      reg_rdata <= `MFD_RST_RDATA;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

// ### rtl/mfd_consts.svh
// Purpose: Offsets, field positions and reset values of the flag and
//          DMA map registers
// Assumes: Byte addresses on an 8-bit register port, one word each
// Notes:   Definitions only
`ifndef MFD_CONSTS_SVH
`define MFD_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define MFD_ADDR_W          8
`define MFD_OFS_MISC        8'h00
`define MFD_OFS_DMA_MAP     8'h04
`define MFD_OFS_ROUTE_CTRL  8'h08

// ****************************************
// Flag register fields
// ****************************************
`define MFD_MISC_EVT_IN     27
`define MFD_MISC_SDIS_HI    26
`define MFD_MISC_SDIS_LO    25
`define MFD_MISC_SUSP_HI    24
`define MFD_MISC_SUSP_LO    23
`define MFD_MISC_FLASH      22
`define MFD_MISC_EVT_OUT_HI 21
`define MFD_MISC_EVT_OUT_LO 20
`define MFD_MISC_SOFT_INTERRUPT      19
`define MFD_MISC_BOOT       14
`define MFD_MISC_SITE2      13
`define MFD_MISC_SITE1      12

// ****************************************
// DMA map and route control fields
// ****************************************
`define MFD_DMA_SEL_HI      1
`define MFD_DMA_SEL_LO      0
`define MFD_ROUTE_EN        0

// ****************************************
// Reset values
// ****************************************
`define MFD_RST_EVT_IN      1'b0
`define MFD_RST_SDIS        2'h3
`define MFD_RST_SUSP        2'h0
`define MFD_RST_FLASH       1'b0
`define MFD_RST_EVT_OUT     2'h0
`define MFD_RST_SOFT_INTERRUPT       1'b0
`define MFD_RST_DMA_SEL     2'h0
`define MFD_RST_ROUTE_EN    1'b0
`define MFD_RST_RDATA       32'h0000_0000

`endif

// ### rtl/mfd_pkg.sv
// Purpose: Types shared by the flag and DMA map register block
// Assumes: Nothing beyond the constants header
// Notes:   Peripheral request lines travel as one packed group
package mfd_pkg;

  // ****************************************
  // DMA pair routing selections
  // ****************************************
  typedef enum logic [1:0] {
    MFD_SEL_AUDIO_RX_TX   = 2'h0,
    MFD_SEL_AUDIO_RX_CARD = 2'h1,
    MFD_SEL_AUDIO_TX_CARD = 2'h2,
    MFD_SEL_SERIAL_RX_TX  = 2'h3
  } mfd_dma_sel_t;

  // ****************************************
  // Peripheral request or acknowledge group, active low
  // ****************************************
  typedef struct packed {
    logic serial_tx;
    logic serial_rx;
    logic card;
    logic audio_tx;
    logic audio_rx;
  } mfd_periph_t;

  // ****************************************
  // Register port request
  // ****************************************
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } mfd_bus_req_t;

endpackage

// ### rtl/mfd_misc_reg.sv
// Purpose: Flag register storage and the pins it drives
// Assumes: Pin inputs synchronous to ref_clk
// Notes:   Suspend lines are released, not driven, when disabled
`timescale 1ns/1ps
`include "mfd_consts.svh"

module mfd_misc_reg (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        wr_en,
  input  wire logic [31:0] wdata,
  input  wire logic        daughter_event_in,
  input  wire logic        boot_master_site,
  input  wire logic        site1_absent,
  input  wire logic        site2_absent,
  output logic      [31:0] rdata,
  output logic             dev_ctrl_suspend_line,
  output logic             dev_ctrl_suspend_line_oe,
  output logic             host_ctrl_suspend_line,
  output logic             host_ctrl_suspend_line_oe,
  output logic             flash_select,
  output logic      [1:0]  daughter_event_out,
  output logic             soft_interrupt
);

  logic       evt_in;
  logic [1:0] suspend_ctrl_disable;
  logic [1:0] suspend;
  logic       next_evt_in;

  // ****************************************
  // Event input capture, set wins over write
  // ****************************************
  assign next_evt_in = daughter_event_in ? 1'b1 :
                       wr_en ? wdata[`MFD_MISC_EVT_IN] : evt_in;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      evt_in               <= `MFD_RST_EVT_IN;
      suspend_ctrl_disable <= `MFD_RST_SDIS;
      suspend              <= `MFD_RST_SUSP;
      flash_select         <= `MFD_RST_FLASH;
      daughter_event_out   <= `MFD_RST_EVT_OUT;
      soft_interrupt       <= `MFD_RST_SOFT_INTERRUPT;
    end else begin
      evt_in <= next_evt_in;
      if (wr_en) begin
        suspend_ctrl_disable <=
          wdata[`MFD_MISC_SDIS_HI:`MFD_MISC_SDIS_LO];
        suspend              <=
          wdata[`MFD_MISC_SUSP_HI:`MFD_MISC_SUSP_LO];
        flash_select         <= wdata[`MFD_MISC_FLASH];
        daughter_event_out   <=
          wdata[`MFD_MISC_EVT_OUT_HI:`MFD_MISC_EVT_OUT_LO];
        soft_interrupt       <= wdata[`MFD_MISC_SOFT_INTERRUPT];
      end
    end
  end

  // ****************************************
  // Suspend pins
  // ****************************************
  assign dev_ctrl_suspend_line     = suspend[0];
  assign host_ctrl_suspend_line    = suspend[1];
  assign dev_ctrl_suspend_line_oe  = ~suspend_ctrl_disable[0];
  assign host_ctrl_suspend_line_oe = ~suspend_ctrl_disable[1];

  // ****************************************
  // Read word, undefined ranges as zero
  // ****************************************
  assign rdata = {4'h0, evt_in, suspend_ctrl_disable, suspend,
                  flash_select, daughter_event_out, soft_interrupt,
                  4'h0, boot_master_site, site2_absent, site1_absent,
                  12'h000};

endmodule

// ### rtl/mfd_dma_route.sv
// Purpose: Routes two DMA request and acknowledge pairs to peripherals
// Assumes: All request and acknowledge lines active low
// Notes:   Pure steering, no transfer logic
`timescale 1ns/1ps

module mfd_dma_route (
  input  wire mfd_pkg::mfd_dma_sel_t dma_sel,
  input  wire logic                  route_en,
  input  wire mfd_pkg::mfd_periph_t  periph_req_n,
  input  wire logic [1:0]            chan_ack_n,
  output logic      [1:0]            chan_req_n,
  output mfd_pkg::mfd_periph_t       periph_ack_n
);

  logic sel_aud_rt;
  logic sel_aud_rc;
  logic sel_aud_tc;
  logic sel_ser;
  logic ch0_src_n;
  logic ch1_src_n;

  // ****************************************
  // Selection decode
  // ****************************************
  assign sel_aud_rt = route_en && dma_sel == mfd_pkg::MFD_SEL_AUDIO_RX_TX;
  assign sel_aud_rc = route_en && dma_sel == mfd_pkg::MFD_SEL_AUDIO_RX_CARD;
  assign sel_aud_tc = route_en && dma_sel == mfd_pkg::MFD_SEL_AUDIO_TX_CARD;
  assign sel_ser    = route_en && dma_sel == mfd_pkg::MFD_SEL_SERIAL_RX_TX;

  // ****************************************
  // Requests toward the external controller
  // ****************************************
  assign ch0_src_n = (sel_aud_rt || sel_aud_rc) ? periph_req_n.audio_rx :
                     sel_aud_tc ? periph_req_n.audio_tx :
                     sel_ser    ? periph_req_n.serial_rx : 1'b1;
  assign ch1_src_n = sel_aud_rt ? periph_req_n.audio_tx :
                     (sel_aud_rc || sel_aud_tc) ? periph_req_n.card :
                     sel_ser    ? periph_req_n.serial_tx : 1'b1;
  assign chan_req_n = {ch1_src_n, ch0_src_n};

  // ****************************************
  // Acknowledges back to peripherals
  // ****************************************
  assign periph_ack_n = '{
    serial_tx: sel_ser ? chan_ack_n[1] : 1'b1,
    serial_rx: sel_ser ? chan_ack_n[0] : 1'b1,
    card:      (sel_aud_rc || sel_aud_tc) ? chan_ack_n[1] : 1'b1,
    audio_tx:  sel_aud_rt ? chan_ack_n[1] :
               sel_aud_tc ? chan_ack_n[0] : 1'b1,
    audio_rx:  (sel_aud_rt || sel_aud_rc) ? chan_ack_n[0] : 1'b1
  };

endmodule

// ### verification/mfd_dmac_model.sv
// Purpose: External DMA controller answering the two routed channels
// Assumes: Active-low request and acknowledge, one clock
// Notes:   Channel one answers slower than channel zero
`timescale 1ns/1ps

module mfd_dmac_model #(
  parameter int DLY0 = 1,
  parameter int DLY1 = 3
) (
  input  wire logic       ref_clk,
  input  wire logic [1:0] req_n,
  output logic      [1:0] ack_n
);
  int cnt [2];

  initial ack_n = 2'h3;

  // Acknowledge each held request after its channel's delay
  always @(posedge ref_clk) begin
    for (int c = 0; c < 2; c++) begin
      cnt[c] <= req_n[c] ? 0 : cnt[c] + 1;
      ack_n[c] <= !(!req_n[c] && cnt[c] >= (c ? DLY1 : DLY0));
    end
  end
endmodule

// ### verification/mfd_top_properties.sv
// Purpose: Port-level properties of the flag and DMA map block
// Assumes: Register strobes one cycle, read data one cycle later
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ps
`include "mfd_consts.svh"

module mfd_top_checker (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        daughter_event_in,
  input wire logic        boot_master_site,
  input wire logic        site1_absent,
  input wire logic        site2_absent,
  input wire logic        dev_ctrl_suspend_line,
  input wire logic        dev_ctrl_suspend_line_oe,
  input wire logic        host_ctrl_suspend_line,
  input wire logic        host_ctrl_suspend_line_oe,
  input wire logic        flash_select,
  input wire logic [1:0]  daughter_event_out,
  input wire logic        soft_interrupt
);
  // ****
  // Properties
  // ****
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_wr_misc;
    reg_wr && reg_addr == `MFD_OFS_MISC;
  endsequence
  sequence s_rd_misc;
    reg_rd && reg_addr == `MFD_OFS_MISC;
  endsequence
  sequence s_evt_rd;
    daughter_event_in ##1 s_rd_misc;
  endsequence

  chk_undef_read_zero: assert property (
    s_rd_misc |=> reg_rdata[31:28] == 4'h0 && reg_rdata[18:15] == 4'h0
      && reg_rdata[11:0] == 12'h000) else $error("undefined bits set");
  chk_event_in_held: assert property (
    s_evt_rd |=> reg_rdata[27]) else $error("event bit not held");
  chk_suspend_release: assert property (
    s_wr_misc |=> {host_ctrl_suspend_line_oe, dev_ctrl_suspend_line_oe}
      == ~$past(reg_wdata[26:25])) else $error("suspend enable wrong");
  chk_suspend_lines: assert property (
    s_wr_misc |=> {host_ctrl_suspend_line, dev_ctrl_suspend_line}
      == $past(reg_wdata[24:23])) else $error("suspend lines wrong");
  chk_flash_select: assert property (
    s_wr_misc |=> flash_select == $past(reg_wdata[22]))
    else $error("flash select wrong");
  chk_event_out: assert property (
    s_wr_misc |=> daughter_event_out == $past(reg_wdata[21:20]))
    else $error("event out wrong");
  chk_soft_irq: assert property (
    s_wr_misc |=> soft_interrupt == $past(reg_wdata[19]))
    else $error("soft interrupt wrong");
  chk_boot_site: assert property (
    s_rd_misc |=> reg_rdata[14] == $past(boot_master_site))
    else $error("boot site wrong");
  chk_site_absent: assert property (
    s_rd_misc |=> reg_rdata[13:12] == $past({site2_absent, site1_absent}))
    else $error("site detect wrong");
  chk_dma_upper_zero: assert property (
    reg_rd && reg_addr == `MFD_OFS_DMA_MAP |=> reg_rdata[31:2] == 30'h0)
    else $error("dma map upper bits set");
  chk_rdata_idle_zero: assert property (
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
endmodule

bind mfd_top mfd_top_checker u_mfd_top_checker (.*);

// ### verification/mfd_top_tb.sv
// Purpose: Self-checking bench of the flag and DMA map block
// Assumes: Register port without wait states
// Notes:   Peripheral requests driven here, controller is a model
`timescale 1ns/1ps
`include "mfd_consts.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin \
  n_mismatch++; $display("ERROR %0t got %h exp %h", $time, a, e); end end

module mfd_top_tb;
  logic                 ref_clk = 1'b0;
  logic                 reset_n = 1'b0;
  logic [7:0]           reg_addr = 8'h00;
  logic [31:0]          reg_wdata = 32'h0;
  logic                 reg_wr = 1'b0;
  logic                 reg_rd = 1'b0;
  logic [31:0]          reg_rdata;
  logic [31:0]          d;
  logic                 daughter_event_in = 1'b0;
  logic                 boot_master_site = 1'b0;
  logic                 site1_absent = 1'b0;
  logic                 site2_absent = 1'b1;
  logic                 dev_ctrl_suspend_line;
  logic                 dev_ctrl_suspend_line_oe;
  logic                 host_ctrl_suspend_line;
  logic                 host_ctrl_suspend_line_oe;
  logic                 flash_select;
  logic [1:0]           daughter_event_out;
  logic                 soft_interrupt;
  mfd_pkg::mfd_periph_t periph_req_n = 5'h1f;
  mfd_pkg::mfd_periph_t periph_ack_n;
  logic [1:0]           dma_req_ack_pair_n_req;
  logic [1:0]           dma_req_ack_pair_n_ack;
  int                   n_mismatch = 0;
  int                   n_compared = 0;

  always #5 ref_clk = ~ref_clk;

  mfd_top u_mfd_top (.*);
  mfd_dmac_model u_mfd_dmac_model (.ref_clk(ref_clk),
    .req_n(dma_req_ack_pair_n_req), .ack_n(dma_req_ack_pair_n_ack));

  // ****
  // Bus tasks
  // ****
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask

  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ****
  // Scenarios
  // ****
  task t_reset;
    rd(`MFD_OFS_MISC);
    `CHK(d, 32'h0600_2000)
    `CHK({flash_select, soft_interrupt}, 2'h0)
    rd(`MFD_OFS_DMA_MAP);
    `CHK(d, 32'h0)
    @(posedge ref_clk);
    periph_req_n <= 5'h00;
    @(negedge ref_clk);
    `CHK({dma_req_ack_pair_n_req, periph_ack_n}, 7'h7f)
    @(posedge ref_clk);
    periph_req_n <= 5'h1f;
    $display("test reset done");
  endtask

  task t_misc;
    @(posedge ref_clk);
    boot_master_site <= 1'b1;
    site2_absent <= 1'b0;
    site1_absent <= 1'b1;
    wr(`MFD_OFS_MISC, 32'hffbf_ffff);
    @(negedge ref_clk);
    `CHK({dev_ctrl_suspend_line_oe, host_ctrl_suspend_line_oe}, 2'h0)
    `CHK({daughter_event_out, soft_interrupt}, 3'h7)
    rd(`MFD_OFS_MISC);
    `CHK(d, 32'h0fb8_5000)
    wr(`MFD_OFS_MISC, 32'h0090_0000);
    @(negedge ref_clk);
    `CHK({host_ctrl_suspend_line, host_ctrl_suspend_line_oe}, 2'h1)
    `CHK({dev_ctrl_suspend_line, dev_ctrl_suspend_line_oe}, 2'h3)
    `CHK({daughter_event_out, soft_interrupt, flash_select}, 4'h4)
    rd(`MFD_OFS_MISC);
    `CHK(d, 32'h0090_5000)
    wr(`MFD_OFS_MISC, 32'h0100_0000);
    @(negedge ref_clk);
    `CHK({host_ctrl_suspend_line, dev_ctrl_suspend_line}, 2'h2)
    $display("test misc done");
  endtask

  task t_event;
    @(posedge ref_clk);
    daughter_event_in <= 1'b1;
    rd(`MFD_OFS_MISC);
    `CHK(d[27], 1'b1)
    @(posedge ref_clk);
    daughter_event_in <= 1'b0;
    wr(`MFD_OFS_MISC, 32'h0);
    rd(`MFD_OFS_MISC);
    `CHK(d[27], 1'b0)
    wr(8'h0c, 32'hffff_ffff);
    rd(8'h0c);
    `CHK(d, 32'h0)
    rd(`MFD_OFS_MISC);
    `CHK(d, 32'h0000_5000)
    $display("test event done");
  endtask

  task t_dma;
    int tbl [8];
    int idx;
    tbl = '{0, 1, 0, 2, 1, 2, 3, 4};
    wr(`MFD_OFS_DMA_MAP, 32'hffff_fffd);
    rd(`MFD_OFS_DMA_MAP);
    `CHK(d, 32'h1)
    wr(`MFD_OFS_ROUTE_CTRL, 32'h1);
    for (int s = 0; s < 4; s++) begin
      wr(`MFD_OFS_DMA_MAP, 32'(s));
      for (int c = 0; c < 2; c++) begin
        idx = tbl[s * 2 + c];
        @(posedge ref_clk);
        periph_req_n <= ~(5'h1 << idx);
        @(negedge ref_clk);
        `CHK(dma_req_ack_pair_n_req, ~(2'h1 << c))
        for (int i = 0; i < 8 && dma_req_ack_pair_n_ack == 2'h3; i++) begin
          @(negedge ref_clk);
        end
        @(negedge ref_clk);
        `CHK(periph_ack_n, ~(5'h1 << idx))
        @(posedge ref_clk);
        periph_req_n <= 5'h1f;
      end
    end
    $display("test dma done");
  endtask

  task t_mid_reset;
    wr(`MFD_OFS_MISC, 32'h0008_0000);
    @(negedge ref_clk);
    `CHK(soft_interrupt, 1'b1)
    wr(`MFD_OFS_ROUTE_CTRL, 32'h1);
    wr(`MFD_OFS_DMA_MAP, 32'h3);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    periph_req_n <= 5'h00;
    @(negedge ref_clk);
    `CHK(soft_interrupt, 1'b0)
    `CHK({dev_ctrl_suspend_line_oe, host_ctrl_suspend_line_oe}, 2'h0)
    `CHK({dma_req_ack_pair_n_req, periph_ack_n}, 7'h7f)
    @(posedge ref_clk);
    periph_req_n <= 5'h1f;
    rd(`MFD_OFS_DMA_MAP);
    `CHK(d, 32'h0)
    $display("test mid reset done");
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset;
    t_misc;
    t_event;
    t_dma;
    t_mid_reset;
    end_sim;
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    n_mismatch++;
    end_sim;
  end
endmodule
